//--- bench/link_status_chk.sv
// Assertions on the link status signal group between the two ends
`timescale 1ns/100ps
module link_status_chk (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Interface signals
    input wire logic pll_locked,
    input wire logic core_ready,
    input wire logic clk_inuse,
    input wire logic dl_up,
    input wire logic dl_exit_n,
    input wire logic fast_time_base_strobe,
    input wire logic us_time_base_strobe,
    input wire logic hot_reset_exit_n,
    input wire logic low_power_exit_pulse_n,
    input wire logic [3:0] lane_active,
    input wire logic [1:0] link_speed,
    input wire logic [4:0] ltssm_state
);
    logic [7:0] fast_cnt_q, fast_cnt_d, us_cnt_q, us_cnt_d;
    logic fast_seen_q, fast_seen_d, us_seen_q, us_seen_d;

    // Cycles since the last strobe
    always_comb begin
        fast_cnt_d = fast_time_base_strobe ? 8'h00 : fast_cnt_q + 8'h01;
        us_cnt_d = us_time_base_strobe ? 8'h00 : us_cnt_q + 8'h01;
        fast_seen_d = fast_seen_q | fast_time_base_strobe;
        us_seen_d = us_seen_q | us_time_base_strobe;
    end
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            fast_cnt_q <= 8'h00;
            us_cnt_q <= 8'h00;
            fast_seen_q <= 1'b0;
            us_seen_q <= 1'b0;
        end else begin
            fast_cnt_q <= fast_cnt_d;
            us_cnt_q <= us_cnt_d;
            fast_seen_q <= fast_seen_d;
            us_seen_q <= us_seen_d;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_low_once(logic x);
        !x ##1 x;
    endsequence

    a_dl_exit_once: assert property (
        $fell(dl_exit_n) |-> s_low_once(dl_exit_n))
        else $error("link exit pulse not one cycle");
    a_dl_exit_cause: assert property (
        $past(rstn_i) |-> ((!dl_exit_n) == $fell(dl_up)))
        else $error("link exit pulse not tied to link up falling");
    a_hot_exit_cause: assert property (
        $past(rstn_i) |-> ((!hot_reset_exit_n) ==
        ($past(ltssm_state) == 5'h14 && ltssm_state != 5'h14)))
        else $error("hot reset exit pulse wrong");
    a_low_power_exit_pulse_n_cause: assert property (
        $past(rstn_i) |-> ((!low_power_exit_pulse_n) ==
        ($past(ltssm_state) == 5'h18 && ltssm_state == 5'h00)))
        else $error("low power exit pulse wrong");
    a_fast_period: assert property (
        fast_time_base_strobe && fast_seen_q |->
        fast_cnt_q == link_status_pkg::FAST_TB_CYC - 1)
        else $error("fast strobe period wrong");
    a_fast_bound: assert property (
        fast_cnt_q <= link_status_pkg::FAST_TB_CYC)
        else $error("fast strobe missing");
    a_us_period: assert property (
        us_time_base_strobe && us_seen_q |->
        us_cnt_q == link_status_pkg::US_TB_CYC - 1)
        else $error("microsecond strobe period wrong");
    a_us_bound: assert property (
        us_cnt_q <= link_status_pkg::US_TB_CYC)
        else $error("microsecond strobe missing");
    a_inuse_needs: assert property (
        clk_inuse |-> $past(pll_locked) && $past(core_ready))
        else $error("clock in use without lock and ready");
    a_lanes_onehot: assert property ($onehot0(lane_active))
        else $error("lane count not one-hot");
    a_ltssm_legal: assert property (ltssm_state <= 5'h1A)
        else $error("training state code out of range");
endmodule

//--- bench/testbench.sv
// Self-checking bench for both ends of the link status group
`timescale 1ns/100ps
module testbench;
    logic clk, rstn, raw_lock, pipe_sim, switched, fsm_up, ext_stable;
    logic [4:0] ltssm;
    logic [3:0] lanes;
    logic [1:0] speed, htrans;
    logic hsel, hwrite, hreadyout, hresp, app_rstn;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int failures, n_tests, n, idx;

    link_status_if ifc();
    link_status_dev i_link_status_dev (.ref_clk_i(clk), .rstn_i(rstn),
        .pll_lock_raw_i(raw_lock), .pipe_sim_i(pipe_sim),
        .tl_clk_switched_i(switched), .data_link_control_fsm_up_i(fsm_up),
        .ltssm_i(ltssm), .lane_num_i(lanes), .speed_i(speed), .lnk(ifc.dev));
    link_status_app i_link_status_app (.ref_clk_i(clk), .rstn_i(rstn),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
        .ext_clk_stable_i(ext_stable), .app_rstn_o(app_rstn), .lnk(ifc.app));
    link_status_chk i_link_status_chk (.ref_clk_i(clk), .rstn_i(rstn),
        .pll_locked(ifc.pll_locked), .core_ready(ifc.core_ready),
        .clk_inuse(ifc.clk_inuse), .dl_up(ifc.dl_up),
        .dl_exit_n(ifc.dl_exit_n),
        .fast_time_base_strobe(ifc.fast_time_base_strobe),
        .us_time_base_strobe(ifc.us_time_base_strobe),
        .hot_reset_exit_n(ifc.hot_reset_exit_n),
        .low_power_exit_pulse_n(ifc.low_power_exit_pulse_n),
        .lane_active(ifc.lane_active), .link_speed(ifc.link_speed),
        .ltssm_state(ifc.ltssm_state));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return ifc.dl_exit_n;
            1: return ifc.hot_reset_exit_n;
            2: return ifc.low_power_exit_pulse_n;
            3: return ifc.fast_time_base_strobe;
            default: return ifc.us_time_base_strobe;
        endcase
    endfunction

    function automatic logic [3:0] exp_lanes(input logic [3:0] c);
        return (c == 4'h1 || c == 4'h2 || c == 4'h4 || c == 4'h8) ? c : 4'h0;
    endfunction

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #80000;
        failures++;
        tally_and_finish();
    end

    initial begin
        {rstn, raw_lock, pipe_sim, switched, fsm_up, ext_stable} = 6'h00;
        {hsel, hwrite, htrans, hsize} = 7'h02;
        {ltssm, lanes, speed} = 11'h000;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        failures = 0;
        n_tests = 0;
        void'($urandom(32'h2648));
        cyc(10);
        rstn <= 1'b1;
        cyc(2);
        check(app_rstn, 1'b0);
        pipe_sim <= 1'b1;
        cyc(2);
        check(ifc.pll_locked, 1'b1);
        pipe_sim <= 1'b0;
        cyc(2);
        check(ifc.pll_locked, 1'b0);
        raw_lock <= 1'b1;
        cyc(2);
        check(ifc.pll_locked, 1'b1);
        bus(1'b1, link_status_pkg::REG_CTRL, 32'h00000001, rd);
        cyc(3);
        check(ifc.core_ready, 1'b0);
        ext_stable <= 1'b1;
        cyc(3);
        check(ifc.core_ready, 1'b1);
        bus(1'b1, link_status_pkg::REG_CTRL, 32'h00000003, rd);
        ext_stable <= 1'b0;
        raw_lock <= 1'b0;
        cyc(4);
        check(ifc.core_ready, 1'b0);
        raw_lock <= 1'b1;
        fsm_up <= 1'b1;
        cyc(4);
        check(ifc.core_ready, 1'b1);
        check(ifc.dl_up, 1'b1);
        switched <= 1'b1;
        do @(posedge clk); while (ifc.clk_inuse !== 1'b1);
        check(app_rstn, 1'b0);
        cyc(2);
        check(app_rstn, 1'b1);
        for (int k = 0; k < 3; k++) begin
            fsm_up <= 1'b0;
            if (k > 0) begin
                ltssm <= (k == 1) ? 5'h14 : 5'h18;
                cyc(2);
                ltssm <= (k == 1) ? 5'h0F : 5'h00;
            end
            do @(posedge clk); while (sig(k) !== 1'b0);
            @(posedge clk);
            check(sig(k), 1'b1);
            n = 1;
            while (app_rstn === 1'b0) begin
                @(posedge clk);
                n++;
            end
            check(n - 1, 32);
            bus(1'b0, link_status_pkg::REG_EVENTS, 32'h00000000, rd);
            check(rd, 32'h00000001 << k);
            bus(1'b1, link_status_pkg::REG_EVENTS, 32'h00000001 << k, rd);
            bus(1'b0, link_status_pkg::REG_EVENTS, 32'h00000000, rd);
            check(rd, 32'h00000000);
        end
        for (int k = 3; k < 5; k++) begin
            do @(posedge clk); while (sig(k) !== 1'b1);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (sig(k) !== 1'b1);
            check(n, (k == 3) ? link_status_pkg::FAST_TB_CYC :
                link_status_pkg::US_TB_CYC);
        end
        for (int i = 0; i < 30; i++) begin
            idx = (i < 4) ? (1 << i) : $urandom_range(0, 9);
            lanes <= idx[3:0];
            speed <= (i < 4) ? i[1:0] : 2'($urandom_range(0, 3));
            ltssm <= (i < 7) ? i[4:0] : 5'($urandom_range(0, 26));
            cyc(2);
            check(ifc.lane_active, exp_lanes(idx[3:0]));
            check(ifc.link_speed, speed);
            check(ifc.ltssm_state, ltssm);
            bus(1'b0, link_status_pkg::REG_STATUS, 32'h00000000, rd);
            check({rd[14:4], rd[2:0]},
                {ltssm, speed, exp_lanes(idx[3:0]), 3'h3});
        end
        bus(1'b0, 8'h10, 32'h00000000, rd);
        check(rd, 32'h00000000);
        tally_and_finish();
    end
endmodule

//--- hw/link_status_app.sv
// Application end of the link status group with bus registers
`timescale 1ns/100ps
module link_status_app (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Bus slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Application side
    input wire logic ext_clk_stable_i,
    output logic app_rstn_o,
    // Core side
    link_status_if.app lnk
);

    logic [1:0] ctrl_q, ctrl_d;
    logic [2:0] ev_q, ev_d;
    logic [31:0] us_cnt_q, us_cnt_d;
    logic ready_q, ready_d;
    link_status_pkg::app_rst_e ar_q, ar_d;
    logic [link_status_pkg::RST_CNT_W-1:0] rc_q, rc_d;
    logic app_rstn_q, app_rstn_d;
    logic wr_q, wr_d;
    logic [7:0] wa_q, wa_d;
    logic [31:0] rd_q, rd_d;
    logic [2:0] exits;
    logic acc;

    function automatic logic [31:0] rd_word(input logic [7:0] a,
        input logic [1:0] c, input logic [2:0] e, input logic [31:0] u,
        input logic [31:0] s);
        logic [31:0] w;
        w = 32'h0;
        case (a)
            link_status_pkg::REG_CTRL: w = {30'h0, c};
            link_status_pkg::REG_STATUS: w = s;
            link_status_pkg::REG_EVENTS: w = {29'h0, e};
            link_status_pkg::REG_US_COUNT: w = u;
            default: w = 32'h0;
        endcase
        return w;
    endfunction

    logic [31:0] status;
    always_comb begin
        status = 32'h0;
        status[link_status_pkg::ST_LOCK] = lnk.pll_locked;
        status[link_status_pkg::ST_INUSE] = lnk.clk_inuse;
        status[link_status_pkg::ST_DLUP] = lnk.dl_up;
        status[link_status_pkg::ST_APP_RST] = !app_rstn_q;
        status[link_status_pkg::ST_LANES +: 4] = lnk.lane_active;
        status[link_status_pkg::ST_SPEED +: 2] = lnk.link_speed;
        status[link_status_pkg::ST_LTSSM +: 5] = lnk.ltssm_state;
    end

    // Bus access and registers
    always_comb begin
        exits = '0;
        exits[link_status_pkg::EV_DL] = !lnk.dl_exit_n;
        exits[link_status_pkg::EV_HOT] = !lnk.hot_reset_exit_n;
        exits[link_status_pkg::EV_L2] = !lnk.low_power_exit_pulse_n;
        acc = hsel_i && htrans_i[1] && hready_i;
        wr_d = acc && hwrite_i;
        wa_d = haddr_i[7:0];
        rd_d = rd_q;
        if (acc && !hwrite_i) begin
            rd_d = rd_word(haddr_i[7:0], ctrl_q, ev_q, us_cnt_q, status);
        end
        ctrl_d = ctrl_q;
        ev_d = ev_q;
        if (wr_q && wa_q == link_status_pkg::REG_CTRL) begin
            ctrl_d = hwdata_i[1:0];
        end
        if (wr_q && wa_q == link_status_pkg::REG_EVENTS) begin
            ev_d = ev_q & ~hwdata_i[2:0];
        end
        ev_d = ev_d | exits;
        us_cnt_d = us_cnt_q + {31'h0, lnk.us_time_base_strobe};
        // (RULE2) (RULE3) Ready from chosen clock
        ready_d = ctrl_q[link_status_pkg::CTRL_READY_EN] &&
                  (ctrl_q[link_status_pkg::CTRL_CORE_CLK] ?
                   lnk.pll_locked : ext_clk_stable_i);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ctrl_q <= link_status_pkg::CTRL_RST;
            ev_q <= '0;
            us_cnt_q <= 32'h0;
            ready_q <= 1'b0;
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            rd_q <= 32'h0;
        end else begin
            ctrl_q <= ctrl_d;
            ev_q <= ev_d;
            us_cnt_q <= us_cnt_d;
            ready_q <= ready_d;
            wr_q <= wr_d;
            wa_q <= wa_d;
            rd_q <= rd_d;
        end
    end

    // Application reset sequencing
    always_comb begin
        ar_d = ar_q;
        rc_d = rc_q;
        case (ar_q)
            // (RULE5) Hold until clock in use
            link_status_pkg::AR_HOLD: begin
                if (lnk.clk_inuse) begin
                    ar_d = link_status_pkg::AR_RUN;
                end
            end
            link_status_pkg::AR_RUN: begin
                if (!lnk.clk_inuse) begin
                    ar_d = link_status_pkg::AR_HOLD;
                end
            end
            // (RULE8) Count exit reset cycles
            link_status_pkg::AR_EXIT: begin
                rc_d = rc_q + 1'b1;
                if (rc_q == link_status_pkg::RST_CNT_W'(
                        link_status_pkg::APP_RST_CYC - 1)) begin
                    ar_d = lnk.clk_inuse ? link_status_pkg::AR_RUN :
                                           link_status_pkg::AR_HOLD;
                end
            end
            default: ar_d = link_status_pkg::AR_HOLD;
        endcase
        // (RULE8) Any exit restarts reset
        if (|exits) begin
            ar_d = link_status_pkg::AR_EXIT;
            rc_d = '0;
        end
        app_rstn_d = (ar_d == link_status_pkg::AR_RUN);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ar_q <= link_status_pkg::AR_HOLD;
            rc_q <= '0;
            app_rstn_q <= 1'b0;
        end else begin
            ar_q <= ar_d;
            rc_q <= rc_d;
            app_rstn_q <= app_rstn_d;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rd_q;
    assign app_rstn_o = app_rstn_q;
    assign lnk.core_ready = ready_q;

endmodule

//--- hw/link_status_dev.sv
// Core end of the link status signal group
//
// What this block and the application end do
// (RULE1) Lock output follows PLL; forced in pipe sim
// (RULE2) Application raises ready only with stable clock
// (RULE3) Ready may be tied to lock output
// (RULE4) Clock-in-use after switch to application clock
// (RULE5) Application held in reset until clock-in-use
// (RULE6) Link-layer-up high while link FSM up
// (RULE7) Link-layer exit: one low cycle
// (RULE8) Exit pulses give 32-cycle application reset
// (RULE9) Fast strobe every 128 ns
// (RULE10) Microsecond strobe every microsecond
// (RULE11) Hot-reset exit: one low cycle
// (RULE12) L2 idle to Detect: one low cycle
// (RULE13) Lane count as 4-bit one-hot
// (RULE14) Link speed as 2-bit code
// (RULE15) Training state as 5-bit code
// (RULE16) Detect.Active is 1; further codes consecutive
`timescale 1ns/100ps
module link_status_dev (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Core internal status
    input wire logic pll_lock_raw_i,
    input wire logic pipe_sim_i,
    input wire logic tl_clk_switched_i,
    input wire logic data_link_control_fsm_up_i,
    input wire logic [4:0] ltssm_i,
    input wire logic [3:0] lane_num_i,
    input wire logic [1:0] speed_i,
    // Application side
    link_status_if.dev lnk
);

    // Binary lane count to one-hot code
    function automatic logic [3:0] lane_code(input logic [3:0] n);
        logic [3:0] c;
        c = link_status_pkg::LANES_NONE;
        case (n)
            4'h1: c = link_status_pkg::LANES_X1;
            4'h2: c = link_status_pkg::LANES_X2;
            4'h4: c = link_status_pkg::LANES_X4;
            4'h8: c = link_status_pkg::LANES_X8;
            default: c = link_status_pkg::LANES_NONE;
        endcase
        return c;
    endfunction

    link_status_pkg::handover_e ho_q, ho_d;
    logic lock_q, lock_d;
    logic inuse_q, inuse_d;

    // Clock handover sequencing
    always_comb begin
        // (RULE1) Lock or pipe sim
        lock_d = pll_lock_raw_i | pipe_sim_i;
        ho_d = ho_q;
        case (ho_q)
            link_status_pkg::HO_WAIT_LOCK: begin
                if (lock_q) begin
                    ho_d = link_status_pkg::HO_WAIT_READY;
                end
            end
            link_status_pkg::HO_WAIT_READY: begin
                if (!lock_q) begin
                    ho_d = link_status_pkg::HO_WAIT_LOCK;
                end else if (lnk.core_ready && tl_clk_switched_i) begin
                    ho_d = link_status_pkg::HO_RUN;
                end
            end
            link_status_pkg::HO_RUN: begin
                if (!lock_q || !lnk.core_ready || !tl_clk_switched_i) begin
                    ho_d = link_status_pkg::HO_WAIT_LOCK;
                end
            end
            default: ho_d = link_status_pkg::HO_WAIT_LOCK;
        endcase
        // (RULE4) In use once switched
        inuse_d = (ho_d == link_status_pkg::HO_RUN);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ho_q <= link_status_pkg::HO_WAIT_LOCK;
            lock_q <= 1'b0;
            inuse_q <= 1'b0;
        end else begin
            ho_q <= ho_d;
            lock_q <= lock_d;
            inuse_q <= inuse_d;
        end
    end

    // Time base dividers
    localparam int NUM_TB = 2;
    localparam int TB_PER [NUM_TB] = '{
        link_status_pkg::FAST_TB_CYC, link_status_pkg::US_TB_CYC};
    logic [NUM_TB-1:0] tb_stb_q;

    genvar g;
    generate
        for (g = 0; g < NUM_TB; g++) begin : g_tb
            localparam logic [link_status_pkg::TB_CNT_W-1:0] LAST =
                link_status_pkg::TB_CNT_W'(TB_PER[g] - 1);
            logic [link_status_pkg::TB_CNT_W-1:0] cnt_q, cnt_d;
            logic stb_d;
            // (RULE9) (RULE10) Periodic strobe
            always_comb begin
                stb_d = (cnt_q == LAST);
                if (stb_d) begin
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            always_ff @(posedge ref_clk_i) begin
                if (!rstn_i) begin
                    cnt_q <= '0;
                    tb_stb_q[g] <= 1'b0;
                end else begin
                    cnt_q <= cnt_d;
                    tb_stb_q[g] <= stb_d;
                end
            end
        end
    endgenerate

    // Link events and status
    localparam int NUM_EV = 3;
    logic dl_up_q, dl_up_d;
    logic [NUM_EV-1:0] ev_hit;
    logic [NUM_EV-1:0] ev_n_q;
    logic [4:0] ltssm_q, ltssm_d;
    logic [3:0] lanes_q, lanes_d;
    logic [1:0] speed_q, speed_d;

    // Exit event causes
    always_comb begin
        // (RULE7) Falling up state
        ev_hit[0] = dl_up_q && !data_link_control_fsm_up_i;
        // (RULE11) Leaving hot reset
        ev_hit[1] = ltssm_q == link_status_pkg::LT_HOT_RESET &&
                    ltssm_i != link_status_pkg::LT_HOT_RESET;
        // (RULE12) L2 idle to Detect
        ev_hit[2] = ltssm_q == link_status_pkg::LT_L2_IDLE &&
                    ltssm_i == link_status_pkg::LT_DETECT_QUIET;
    end

    always_comb begin
        // (RULE6) Follows link FSM up
        dl_up_d = data_link_control_fsm_up_i;
        // (RULE15) (RULE16) State code passthrough
        ltssm_d = ltssm_i;
        // (RULE13) One-hot lane count
        lanes_d = lane_code(lane_num_i);
        // (RULE14) Speed code
        speed_d = speed_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            dl_up_q <= 1'b0;
            ltssm_q <= link_status_pkg::LT_DETECT_QUIET;
            lanes_q <= link_status_pkg::LANES_NONE;
            speed_q <= link_status_pkg::SPEED_UNDEF;
        end else begin
            dl_up_q <= dl_up_d;
            ltssm_q <= ltssm_d;
            lanes_q <= lanes_d;
            speed_q <= speed_d;
        end
    end

    // Exit events as one low cycle each
    generate
        for (g = 0; g < NUM_EV; g++) begin : g_ev
            logic ev_n_d;
            // (RULE7) (RULE11) (RULE12) Active-low pulse
            always_comb begin
                ev_n_d = 1'b1;
                if (ev_hit[g]) begin
                    ev_n_d = 1'b0;
                end
            end
            always_ff @(posedge ref_clk_i) begin
                if (!rstn_i) begin
                    ev_n_q[g] <= 1'b1;
                end else begin
                    ev_n_q[g] <= ev_n_d;
                end
            end
        end
    endgenerate

    // Drive the group from flops
    assign lnk.pll_locked = lock_q;
    assign lnk.clk_inuse = inuse_q;
    assign lnk.dl_up = dl_up_q;
    assign lnk.dl_exit_n = ev_n_q[0];
    assign lnk.fast_time_base_strobe = tb_stb_q[0];
    assign lnk.us_time_base_strobe = tb_stb_q[1];
    assign lnk.hot_reset_exit_n = ev_n_q[1];
    assign lnk.low_power_exit_pulse_n = ev_n_q[2];
    assign lnk.lane_active = lanes_q;
    assign lnk.link_speed = speed_q;
    assign lnk.ltssm_state = ltssm_q;

endmodule

//--- hw/link_status_if.sv
// Status signal group between core and application
`timescale 1ns/100ps
interface link_status_if;
    logic pll_locked;
    logic core_ready;
    logic clk_inuse;
    logic dl_up;
    logic dl_exit_n;
    logic fast_time_base_strobe;
    logic us_time_base_strobe;
    logic hot_reset_exit_n;
    logic low_power_exit_pulse_n;
    logic [3:0] lane_active;
    logic [1:0] link_speed;
    logic [4:0] ltssm_state;

    modport dev (
        input core_ready,
        output pll_locked, clk_inuse, dl_up, dl_exit_n,
        output fast_time_base_strobe, us_time_base_strobe,
        output hot_reset_exit_n, low_power_exit_pulse_n,
        output lane_active, link_speed, ltssm_state
    );
    modport app (
        output core_ready,
        input pll_locked, clk_inuse, dl_up, dl_exit_n,
        input fast_time_base_strobe, us_time_base_strobe,
        input hot_reset_exit_n, low_power_exit_pulse_n,
        input lane_active, link_speed, ltssm_state
    );
endinterface

//--- hw/link_status_pkg.sv
// Shared constants and types for the link status signal group
package link_status_pkg;
    // Clock and time bases
    localparam int CLK_PERIOD_PS = 4000;
    localparam int FAST_TB_NS = 128;
    localparam int US_TB_NS = 1000;
    localparam int FAST_TB_CYC = FAST_TB_NS * 1000 / CLK_PERIOD_PS;
    localparam int US_TB_CYC = US_TB_NS * 1000 / CLK_PERIOD_PS;
    localparam int TB_CNT_W = 8;
    localparam int APP_RST_CYC = 32;
    localparam int RST_CNT_W = 6;
    // Lane count one-hot codes
    localparam logic [3:0] LANES_NONE = 4'h0;
    localparam logic [3:0] LANES_X1 = 4'h1;
    localparam logic [3:0] LANES_X2 = 4'h2;
    localparam logic [3:0] LANES_X4 = 4'h4;
    localparam logic [3:0] LANES_X8 = 4'h8;
    // Link speed codes
    localparam logic [1:0] SPEED_UNDEF = 2'h0;
    localparam logic [1:0] SPEED_GEN1 = 2'h1;
    localparam logic [1:0] SPEED_GEN2 = 2'h2;
    localparam logic [1:0] SPEED_GEN3 = 2'h3;
    // Training state codes
    typedef enum logic [4:0] {
        LT_DETECT_QUIET = 5'h00, LT_DETECT_ACTIVE = 5'h01,
        LT_POLL_ACTIVE = 5'h02, LT_POLL_COMPLIANCE = 5'h03,
        LT_POLL_CONFIG = 5'h04, LT_POLL_SPEED = 5'h05,
        LT_CFG_LW_START = 5'h06, LT_CFG_LW_ACCEPT = 5'h07,
        LT_CFG_LN_ACCEPT = 5'h08, LT_CFG_LN_WAIT = 5'h09,
        LT_CFG_COMPLETE = 5'h0A, LT_CFG_IDLE = 5'h0B,
        LT_RCV_LOCK = 5'h0C, LT_RCV_CFG = 5'h0D,
        LT_RCV_IDLE = 5'h0E, LT_L0 = 5'h0F, LT_DISABLED = 5'h10,
        LT_LPBK_ENTRY = 5'h11, LT_LPBK_ACTIVE = 5'h12,
        LT_LPBK_EXIT = 5'h13, LT_HOT_RESET = 5'h14, LT_L0S = 5'h15,
        LT_L1_ENTRY = 5'h16, LT_L1_IDLE = 5'h17, LT_L2_IDLE = 5'h18,
        LT_L2_WAKE = 5'h19, LT_RCV_SPEED = 5'h1A
    } ltssm_e;
    // Clock handover states
    typedef enum logic [1:0] {
        HO_WAIT_LOCK = 2'h0, HO_WAIT_READY = 2'h1, HO_RUN = 2'h3
    } handover_e;
    // Application reset states
    typedef enum logic [1:0] {
        AR_HOLD = 2'h0, AR_RUN = 2'h1, AR_EXIT = 2'h3
    } app_rst_e;
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_EVENTS = 8'h08;
    localparam logic [7:0] REG_US_COUNT = 8'h0C;
    localparam logic [1:0] CTRL_RST = 2'h0;
    // Field positions
    localparam int CTRL_READY_EN = 0;
    localparam int CTRL_CORE_CLK = 1;
    localparam int ST_LOCK = 0;
    localparam int ST_INUSE = 1;
    localparam int ST_DLUP = 2;
    localparam int ST_APP_RST = 3;
    localparam int ST_LANES = 4;
    localparam int ST_SPEED = 8;
    localparam int ST_LTSSM = 10;
    localparam int EV_DL = 0;
    localparam int EV_HOT = 1;
    localparam int EV_L2 = 2;
endpackage
